// ==== dv/wcd_top_test.sv ====
// Purpose: Self-checking bench for the watchdog config decode block
// Assumes: One-cycle Wishbone answer, 20-cycle timebase tick
// Notes:   Reads are noted in a queue and compared by a monitor
`timescale 1ns/10ps

module wcd_top_test;
  import wcd_pkg::*;

  logic        core_clk;
  logic        rst_n;
  logic [31:0] cfg_word;
  wcd_wb_req_t wb_req;
  wcd_wb_rsp_t wb_rsp;
  logic        wdt_timeout;
  logic [63:0] exp_q[$];
  logic [31:0] lfsr;
  int          err_count;
  int          total_checks;
  int          pulses;
  int          ws[4] = '{2, 4, 5, 6};

  wcd_top uut (
    .core_clk    (core_clk),
    .rst_n       (rst_n),
    .cfg_word    (cfg_word),
    .wb_req      (wb_req),
    .wb_rsp      (wb_rsp),
    .wdt_timeout (wdt_timeout)
  );

  initial core_clk = 1'b0;
  always #25 core_clk = ~core_clk;

  function automatic logic [31:0] nxt_rand(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  // Reserved bits one, oscillator mode never 11
  function automatic logic [31:0] mk(input logic [1:0] w, input logic h, input logic d,
                                     input logic [4:0] p, input logic [15:0] r);
    return {6'h3f, w, h, d, 1'b1, p, r & 16'hfdff};
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_of_test();
    $display("TB: checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: dat};
    do begin
      @(posedge core_clk);
      n++;
    end while (wb_rsp.ack !== 1'b1 && n < 50);
    if (n >= 50) chk("bus ack", 32'h1, 32'h0);
    wb_req <= '0;
    @(posedge core_clk);
  endtask

  task automatic rd(input logic [7:0] adr, input logic [31:0] m, input logic [31:0] e);
    exp_q.push_back({m, e});
    bus(1'b0, adr, 32'h0);
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] d);
    bus(1'b1, adr, d);
  endtask

  task automatic restart(input logic [31:0] cfg);
    rst_n    <= 1'b0;
    cfg_word <= cfg;
    lfsr = nxt_rand(lfsr);
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    pulses = 0;
  endtask

  // Monitor: each read answer is compared with the oldest note
  always @(posedge core_clk) begin
    logic [63:0] e;
    if (wb_rsp.ack === 1'b1 && wb_req.we === 1'b0) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 64'hffff_ffff_dead_beef;
      chk("read data", e[31:0], wb_rsp.dat & e[63:32]);
    end
    if (wdt_timeout === 1'b1) pulses++;
  end

  initial begin
    int          s;
    logic [31:0] c;
    rst_n = 1'b0;
    cfg_word = 32'h0;
    wb_req = '0;
    lfsr = 32'hf0b4;
    err_count = 0;
    total_checks = 0;
    pulses = 0;
    // Capture, hold, read-only config, unmapped place
    c = mk(2'h2, 1'b1, 1'b1, 5'h1f, lfsr[15:0]);
    restart(c);
    rd(WCD_ADR_CFG, 32'hffffffff, c);
    cfg_word <= ~c;
    wr(WCD_ADR_CFG, lfsr);
    rd(WCD_ADR_CFG, 32'hffffffff, c);
    wr(WCD_ADR_CTRL, 32'h2);
    rd(WCD_ADR_STAT, 32'h17, 32'h01);
    wr(8'h10, nxt_rand(lfsr));
    rd(8'h10, 32'hffffffff, 32'h0);
    $display("test done: capture");
    // Postscale ratio by timeout spacing, software off ignored
    for (int k = 0; k < 4; k++) begin
      restart(mk(2'h0, 1'b1, 1'b1, 5'(k), lfsr[15:0]));
      wr(WCD_ADR_CTRL, 32'h0);
      repeat (80 * (1 << k) + 7) @(posedge core_clk);
      chk("timeout pulses", 32'd4, pulses);
      rd(WCD_ADR_STAT, 32'h17, 32'h03);
    end
    $display("test done: postscale");
    // Software enable path
    restart(mk(2'h0, 1'b0, 1'b1, 5'h00, lfsr[15:0]));
    repeat (60) @(posedge core_clk);
    chk("idle pulses", 32'd0, pulses);
    rd(WCD_ADR_STAT, 32'h1, 32'h0);
    wr(WCD_ADR_CTRL, 32'h1);
    pulses = 0;
    repeat (90) @(posedge core_clk);
    chk("enabled pulses", 32'd4, pulses);
    $display("test done: soft enable");
    // Window edges: one tick before start errs, at start is fine
    for (int w = 0; w < 8; w++) begin
      s = ws[w % 4];
      restart(mk(2'(w % 4), 1'b1, 1'b0, 5'h03, lfsr[15:0]));
      repeat (w < 4 ? 20 * s - 12 : 20 * s + 8) @(posedge core_clk);
      wr(WCD_ADR_CTRL, 32'h2);
      repeat (3) @(posedge core_clk);
      chk("kick pulse", w < 4 ? 32'd1 : 32'd0, pulses);
      rd(WCD_ADR_STAT, 32'h1d, w < 4 ? 32'h15 : 32'h11);
      rd(WCD_ADR_CNT, 32'h1fffff, 32'h0);
      wr(WCD_ADR_STAT, 32'h6);
      rd(WCD_ADR_STAT, 32'h6, 32'h0);
    end
    $display("test done: window");
    // Unlisted postscale code behaves as the top ratio
    restart(mk(2'h0, 1'b1, 1'b0, 5'h1f, lfsr[15:0]));
    repeat (40) @(posedge core_clk);
    wr(WCD_ADR_CTRL, 32'h2);
    repeat (3) @(posedge core_clk);
    chk("top code kick", 32'd1, pulses);
    $display("test done: top code");
    end_of_test();
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    $display("BAD watchdog expected done seen hang");
    end_of_test();
  end
endmodule // wcd_top_test

// ==== hw/wcd_pkg.sv ====
// Purpose: Shared constants and types for the watchdog config decode block
// Assumes: 20 MHz core clock, classic Wishbone register access
// Notes:   Config word comes from nonvolatile storage outside this block
package wcd_pkg;
  localparam int WCD_CLK_NS   = 50;
  localparam int WCD_TB_NS    = 1000;
  localparam int WCD_TB_CYC   = (WCD_TB_NS + WCD_CLK_NS - 1) / WCD_CLK_NS;
  localparam int WCD_PRE_W    = 5;
  localparam int WCD_POST_W   = 21;
  localparam logic [WCD_PRE_W-1:0]  WCD_PRE_LAST = WCD_PRE_W'(WCD_TB_CYC - 1);
  localparam logic [WCD_PRE_W-1:0]  WCD_PRE_ZERO = 5'h00;
  localparam logic [WCD_PRE_W-1:0]  WCD_PRE_ONE  = 5'h01;
  localparam logic [WCD_POST_W-1:0] WCD_POST_ZERO = 21'h000000;
  localparam logic [WCD_POST_W-1:0] WCD_POST_ONE  = 21'h000001;

  localparam int WCD_WINSZ_LSB  = 24;
  localparam int WCD_HWEN_BIT   = 23;
  localparam int WCD_WDT_WINDOW_DISABLE_BIT = 22;
  localparam int WCD_PS_LSB     = 16;
  localparam logic [4:0] WCD_PS_MAX = 5'h14;

  localparam logic [1:0] WCD_WIN_25  = 2'h3;
  localparam logic [1:0] WCD_WIN_375 = 2'h2;
  localparam logic [1:0] WCD_WIN_50  = 2'h1;
  localparam logic [1:0] WCD_WIN_75  = 2'h0;

  localparam logic [7:0] WCD_ADR_CFG  = 8'h00;
  localparam logic [7:0] WCD_ADR_CTRL = 8'h04;
  localparam logic [7:0] WCD_ADR_STAT = 8'h08;
  localparam logic [7:0] WCD_ADR_CNT  = 8'h0c;

  localparam int WCD_CTRL_EN   = 0;
  localparam int WCD_CTRL_KICK = 1;
  localparam int WCD_ST_RUN    = 0;
  localparam int WCD_ST_TO     = 1;
  localparam int WCD_ST_WERR   = 2;
  localparam int WCD_ST_WOPEN  = 3;
  localparam int WCD_ST_WMODE  = 4;

  localparam logic [31:0] WCD_CFG_RST  = 32'h0000_0000;
  localparam logic [31:0] WCD_DAT_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {
    WCD_LOAD = 2'b01,
    WCD_OPER = 2'b10
  } wcd_phase_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wcd_wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } wcd_wb_rsp_t;

  typedef struct packed {
    wcd_phase_t              phase;
    logic [31:0]             cfg;
    logic [WCD_PRE_W-1:0]    pre;
    logic [WCD_POST_W-1:0]   post;
    logic                    sw_en;
    logic                    to_flag;
    logic                    werr_flag;
    logic                    to_pulse;
    logic                    ack;
    logic [31:0]             rdata;
  } wcd_state_t;
endpackage

// ==== hw/wcd_top.sv ====
// Purpose: Watchdog fed by the fields of the watchdog/oscillator config word
// Assumes: Config word stable at reset release; inputs synchronous to core_clk
// Notes:   Registers reached over classic Wishbone, one cycle answer
//
// Register access over Wishbone and the address map were left to the implementer.
`timescale 1ns/10ps

module wcd_top (
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic [31:0]  cfg_word,
  input  wire wcd_pkg::wcd_wb_req_t wb_req,
  output wcd_pkg::wcd_wb_rsp_t      wb_rsp,
  output logic              wdt_timeout
);
  import wcd_pkg::*;

  function automatic logic [WCD_POST_W-1:0] wcd_ratio(
    input logic [4:0] code
  );
    logic [4:0] eff;
    eff = (code > WCD_PS_MAX) ? WCD_PS_MAX : code;
    return WCD_POST_ONE << eff;
  endfunction

  function automatic logic [WCD_POST_W-1:0] wcd_win_start(
    input logic [1:0]            sel,
    input logic [WCD_POST_W-1:0] r
  );
    logic [WCD_POST_W-1:0] q;
    logic [WCD_POST_W-1:0] e;
    q = r >> 2;
    e = r >> 3;
    case (sel)
      WCD_WIN_25:  return r - q;
      WCD_WIN_375: return r - (q + e);
      WCD_WIN_50:  return r >> 1;
      WCD_WIN_75:  return q;
      default:     return q;
    endcase
  endfunction

  wcd_state_t s_ff;
  wcd_state_t nxt_s;

  logic [1:0]            win_sel;
  logic                  hw_en;
  logic                  win_dis;
  logic [4:0]            ps_code;
  logic [WCD_POST_W-1:0] ratio;
  logic [WCD_POST_W-1:0] win_start;
  logic                  running;
  logic                  win_open;
  logic                  take;
  logic                  wr_lo;
  logic                  kick;
  logic                  early;
  logic                  tick;
  logic                  to_evt;
  logic                  clr_to;
  logic                  clr_werr;
  logic [31:0]           rd_mux;

  // Field decode of the captured word
  always_comb begin
    win_sel   = s_ff.cfg[WCD_WINSZ_LSB +: 2];
    hw_en     = s_ff.cfg[WCD_HWEN_BIT];
    win_dis   = s_ff.cfg[WCD_WDT_WINDOW_DISABLE_BIT];
    ps_code   = s_ff.cfg[WCD_PS_LSB +: 5];
    ratio     = wcd_ratio(ps_code);
    win_start = wcd_win_start(win_sel, ratio);
    running   = (s_ff.phase == WCD_OPER) && (hw_en || s_ff.sw_en);
    win_open  = !win_dis && (s_ff.post >= win_start);
  end

  always_comb begin
    nxt_s          = s_ff;
    nxt_s.to_pulse = 1'b0;
    take     = wb_req.cyc && wb_req.stb && !s_ff.ack;
    wr_lo    = take && wb_req.we && wb_req.sel[0];
    kick     = 1'b0;
    early    = 1'b0;
    tick     = 1'b0;
    to_evt   = 1'b0;
    clr_to   = 1'b0;
    clr_werr = 1'b0;
    rd_mux   = WCD_DAT_ZERO;
    nxt_s.ack = take;

    // Capture once after reset release
    case (s_ff.phase)
      WCD_LOAD: begin
        nxt_s.cfg   = cfg_word;
        nxt_s.phase = WCD_OPER;
      end
      WCD_OPER: begin
        nxt_s.phase = WCD_OPER;
      end
      default: begin
        nxt_s.phase = WCD_LOAD;
      end
    endcase

    // Control and status writes
    if (wr_lo && (wb_req.adr == WCD_ADR_CTRL)) begin
      nxt_s.sw_en = wb_req.dat[WCD_CTRL_EN];
      kick        = wb_req.dat[WCD_CTRL_KICK];
    end
    if (wr_lo && (wb_req.adr == WCD_ADR_STAT)) begin
      clr_to   = wb_req.dat[WCD_ST_TO];
      clr_werr = wb_req.dat[WCD_ST_WERR];
    end

    // Timebase and postscale counting
    if (!running) begin
      nxt_s.pre  = WCD_PRE_ZERO;
      nxt_s.post = WCD_POST_ZERO;
    end else begin
      tick      = (s_ff.pre == WCD_PRE_LAST);
      nxt_s.pre = tick ? WCD_PRE_ZERO : s_ff.pre + WCD_PRE_ONE;
      if (kick) begin
        early      = !win_dis && (s_ff.post < win_start);
        nxt_s.post = WCD_POST_ZERO;
        nxt_s.pre  = WCD_PRE_ZERO;
      end else if (tick) begin
        if (s_ff.post == ratio - WCD_POST_ONE) begin
          to_evt     = 1'b1;
          nxt_s.post = WCD_POST_ZERO;
        end else begin
          nxt_s.post = s_ff.post + WCD_POST_ONE;
        end
      end
    end

    // Sticky flags, a set beats a clear
    if (clr_to) begin
      nxt_s.to_flag = 1'b0;
    end
    if (clr_werr) begin
      nxt_s.werr_flag = 1'b0;
    end
    if (to_evt) begin
      nxt_s.to_flag = 1'b1;
    end
    if (early) begin
      nxt_s.werr_flag = 1'b1;
    end
    nxt_s.to_pulse = to_evt || early;

    // Read data
    case (wb_req.adr)
      WCD_ADR_CFG: begin
        rd_mux = s_ff.cfg;
      end
      WCD_ADR_CTRL: begin
        rd_mux[WCD_CTRL_EN] = s_ff.sw_en;
      end
      WCD_ADR_STAT: begin
        rd_mux[WCD_ST_RUN]   = running;
        rd_mux[WCD_ST_TO]    = s_ff.to_flag;
        rd_mux[WCD_ST_WERR]  = s_ff.werr_flag;
        rd_mux[WCD_ST_WOPEN] = win_open;
        rd_mux[WCD_ST_WMODE] = !win_dis;
      end
      WCD_ADR_CNT: begin
        rd_mux[WCD_POST_W-1:0] = s_ff.post;
      end
      default: begin
        rd_mux = WCD_DAT_ZERO;
      end
    endcase
    if (take && !wb_req.we) begin
      nxt_s.rdata = rd_mux;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_ff.phase     <= WCD_LOAD;
      s_ff.cfg       <= WCD_CFG_RST;
      s_ff.pre       <= WCD_PRE_ZERO;
      s_ff.post      <= WCD_POST_ZERO;
      s_ff.sw_en     <= 1'b0;
      s_ff.to_flag   <= 1'b0;
      s_ff.werr_flag <= 1'b0;
      s_ff.to_pulse  <= 1'b0;
      s_ff.ack       <= 1'b0;
      s_ff.rdata     <= WCD_DAT_ZERO;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign wb_rsp.ack  = s_ff.ack;
  assign wb_rsp.dat  = s_ff.rdata;
  assign wdt_timeout = s_ff.to_pulse;

  default clocking wcd_cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  a_cfg_held: assert property (
    (s_ff.phase == WCD_OPER) |=> $stable(s_ff.cfg) && (s_ff.phase == WCD_OPER)
  ) else $error("config word changed after capture");

  a_hw_en_runs: assert property (
    (s_ff.phase == WCD_OPER) && hw_en && !kick && (s_ff.pre != WCD_PRE_LAST)
    |=> (s_ff.pre == $past(s_ff.pre) + WCD_PRE_ONE)
  ) else $error("hardware enabled watchdog not counting");

  a_sw_off_ignored: assert property (
    wr_lo && (wb_req.adr == WCD_ADR_CTRL) && !wb_req.dat[WCD_CTRL_EN] && hw_en
    && (s_ff.phase == WCD_OPER) |=> running [*2]
  ) else $error("software turned off hardware enabled watchdog");

  a_start_off: assert property (
    $rose(s_ff.phase == WCD_OPER) && !hw_en |-> !running
  ) else $error("watchdog running without enable after reset");

  a_sw_enable: assert property (
    wr_lo && (wb_req.adr == WCD_ADR_CTRL) && wb_req.dat[WCD_CTRL_EN]
    && (s_ff.phase == WCD_OPER) |=> running
  ) else $error("software enable had no effect");

  a_early_kick: assert property (
    running && kick && !win_dis && (s_ff.post < win_start)
    |=> s_ff.werr_flag && s_ff.to_pulse && (s_ff.post == WCD_POST_ZERO)
  ) else $error("early clear in window mode not flagged");

  a_nowin_kick: assert property (
    running && kick && win_dis |=> !s_ff.to_pulse && (s_ff.post == WCD_POST_ZERO)
  ) else $error("clear in non-window mode misbehaved");

  a_win_quarter: assert property (
    (win_sel == WCD_WIN_25) && (ps_code == 5'h03) |-> (win_start == 21'h000006)
  ) else $error("window start wrong for quarter window");

  a_ratio_clamp: assert property (
    (ps_code > WCD_PS_MAX) |-> (ratio == 21'h100000)
  ) else $error("postscale code above top not clamped");

  a_post_bound: assert property (
    running |-> (s_ff.post < ratio)
  ) else $error("postscale count beyond ratio");

  a_timeout_pulse: assert property (
    running && tick && !kick && (s_ff.post == ratio - WCD_POST_ONE)
    |=> wdt_timeout && s_ff.to_flag && (s_ff.post == WCD_POST_ZERO)
    ##1 (wdt_timeout == $past(early))
  ) else $error("timeout not raised at end of period");

  a_ack_single: assert property (
    wb_req.cyc && wb_req.stb && !s_ff.ack |=> s_ff.ack ##1 !s_ff.ack
  ) else $error("bus answer not a single cycle");

endmodule // wcd_top
